// ==== autoneg_np_pkg.sv ====
// constants, field layouts and carriers for the auto-negotiation next-page register bank
package autoneg_np_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int IDX_W  = 6;

  // register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_PARTNER_ABILITY = 6'h05;
  localparam logic [IDX_W-1:0] IDX_EXPANSION       = 6'h06;
  localparam logic [IDX_W-1:0] IDX_NP_TRANSMIT     = 6'h07;
  localparam logic [IDX_W-1:0] IDX_NP_RECEIVED     = 6'h08;
  localparam logic [IDX_W-1:0] IDX_CONTROL         = 6'h10;
  localparam logic [IDX_W-1:0] IDX_IRQ_STATUS      = 6'h11;
  localparam logic [IDX_W-1:0] IDX_IRQ_MASK        = 6'h12;

  // expansion status field positions
  localparam int EXP_PD_FAULT   = 4;
  localparam int EXP_PARTNER_NP = 3;
  localparam int EXP_LOCAL_NP   = 2;
  localparam int EXP_PAGE_RX    = 1;
  localparam int EXP_PARTNER_AN = 0;

  // partner ability: 100 Mb/s ability bit
  localparam int LPA_100TX = 7;

  // control and interrupt field positions
  localparam int CTRL_AN_ENABLE = 0;
  localparam int IRQ_PD_FAULT   = 0;
  localparam int IRQ_PAGE_RX    = 1;
  localparam int IRQ_W          = 2;

  // values after reset
  localparam logic        LOCAL_NP_ABLE_RESET = 1'b1;
  localparam logic        AN_ENABLE_RESET     = 1'b1;
  localparam logic [10:0] NP_TX_CODE_RESET    = 11'h001;
  localparam logic [10:0] NP_RX_CODE_RESET    = 11'h000;
  localparam logic [15:0] LPA_RESET           = 16'h0000;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RESET = 2'h0;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // one next-page code word
  typedef struct packed {
    logic        more;
    logic        rsvd;
    logic        message_page_select;
    logic        acknowledge_two;
    logic        toggle;
    logic [10:0] page_code_field;
  } np_word_s;

  // one register write taken from the bus
  typedef struct packed {
    logic              en;
    logic [IDX_W-1:0]  idx;
    logic [DATA_W-1:0] data;
    logic [3:0]        strb;
  } reg_wr_s;

  typedef enum logic [0:0] {W_COLLECT = 1'b0, W_RESP = 1'b1} wr_state_e;
  typedef enum logic [0:0] {R_IDLE = 1'b0, R_DATA = 1'b1} rd_state_e;

endpackage : autoneg_np_pkg

// ==== reg_bus_slave.sv ====
// AXI4-Lite slave front end: takes one write and one read at a time
`timescale 1ns/1ps
`default_nettype none
module reg_bus_slave
  import autoneg_np_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              awvalid,
  output var  logic              awready,
  input  wire logic [DATA_W-1:0] wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output var  logic              wready,
  output var  logic [1:0]        bresp,
  output var  logic              bvalid,
  input  wire logic              bready,
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic              arvalid,
  output var  logic              arready,
  output var  logic [DATA_W-1:0] rdata,
  output var  logic [1:0]        rresp,
  output var  logic              rvalid,
  input  wire logic              rready,
  output var  reg_wr_s           wr,
  input  wire logic              wr_ok,
  output var  logic [IDX_W-1:0]  rd_idx,
  input  wire logic [DATA_W-1:0] rd_data,
  input  wire logic              rd_ok,
  output var  logic              rd_fire,
  output var  logic [IDX_W-1:0]  rd_done_idx
);

  wr_state_e         wstate, next_wstate;
  rd_state_e         rstate, next_rstate;
  logic [IDX_W-1:0]  wr_idx, next_wr_idx;
  logic [DATA_W-1:0] wr_data, next_wr_data;
  logic [3:0]        wr_strb, next_wr_strb;
  logic              next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
  logic [1:0]        next_bresp, next_rresp;
  logic [DATA_W-1:0] next_rdata;
  logic [IDX_W-1:0]  next_rd_done_idx;

  // address and data may arrive in either order; both are held until the write
  always_comb begin
    next_wstate  = wstate;
    next_awready = awready;
    next_wready  = wready;
    next_bvalid  = bvalid;
    next_bresp   = bresp;
    next_wr_idx  = wr_idx;
    next_wr_data = wr_data;
    next_wr_strb = wr_strb;
    wr           = '0;
    unique case (wstate)
      W_COLLECT: begin
        if (awvalid && awready) begin
          next_wr_idx  = awaddr[IDX_W+1:2];
          next_awready = 1'b0;
        end
        if (wvalid && wready) begin
          next_wr_data = wdata;
          next_wr_strb = wstrb;
          next_wready  = 1'b0;
        end
        if (!awready && !wready) begin
          wr.en       = 1'b1;
          wr.idx      = wr_idx;
          wr.data     = wr_data;
          wr.strb     = wr_strb;
          next_bresp  = wr_ok ? RESP_OKAY : RESP_SLVERR;
          next_bvalid = 1'b1;
          next_wstate = W_RESP;
        end
      end
      W_RESP: begin
        if (bready) begin
          next_bvalid  = 1'b0;
          next_awready = 1'b1;
          next_wready  = 1'b1;
          next_wstate  = W_COLLECT;
        end
      end
    endcase
  end

  assign rd_idx  = araddr[IDX_W+1:2];
  assign rd_fire = rvalid && rready;

  // read data is frozen at address accept so read-clear acts on what was returned
  always_comb begin
    next_rstate      = rstate;
    next_arready     = arready;
    next_rvalid      = rvalid;
    next_rdata       = rdata;
    next_rresp       = rresp;
    next_rd_done_idx = rd_done_idx;
    unique case (rstate)
      R_IDLE: begin
        if (arvalid) begin
          next_rdata       = rd_data;
          next_rresp       = rd_ok ? RESP_OKAY : RESP_SLVERR;
          next_rd_done_idx = rd_idx;
          next_arready     = 1'b0;
          next_rvalid      = 1'b1;
          next_rstate      = R_DATA;
        end
      end
      R_DATA: begin
        if (rready) begin
          next_rvalid  = 1'b0;
          next_arready = 1'b1;
          next_rstate  = R_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wstate      <= W_COLLECT;
      rstate      <= R_IDLE;
      awready     <= 1'b1;
      wready      <= 1'b1;
      bvalid      <= 1'b0;
      bresp       <= RESP_OKAY;
      wr_idx      <= '0;
      wr_data     <= '0;
      wr_strb     <= '0;
      arready     <= 1'b1;
      rvalid      <= 1'b0;
      rdata       <= '0;
      rresp       <= RESP_OKAY;
      rd_done_idx <= '0;
    end else begin
      wstate      <= next_wstate;
      rstate      <= next_rstate;
      awready     <= next_awready;
      wready      <= next_wready;
      bvalid      <= next_bvalid;
      bresp       <= next_bresp;
      wr_idx      <= next_wr_idx;
      wr_data     <= next_wr_data;
      wr_strb     <= next_wr_strb;
      arready     <= next_arready;
      rvalid      <= next_rvalid;
      rdata       <= next_rdata;
      rresp       <= next_rresp;
      rd_done_idx <= next_rd_done_idx;
    end
  end

endmodule : reg_bus_slave
`default_nettype wire

// ==== autoneg_next_page_regs.sv ====
// auto-negotiation expansion status and next-page register bank behind AXI4-Lite
`timescale 1ns/1ps
`default_nettype none
// Operation
// RULE1 - parallel detection fault sets expansion bit 4; a read clears it
// RULE2 - expansion bit 3 shows partner next-page ability, read only
// RULE3 - expansion bit 2 shows local next-page ability, 1 after reset
// RULE4 - a new page from the partner sets expansion bit 1; a read clears it
// RULE5 - expansion bit 0 shows partner negotiation ability while negotiation is enabled
// RULE6 - transmit next-page register at index 7 holds the page sent to the partner
// RULE7 - software sets transmit bit 15 when more pages follow, clears on last
// RULE8 - code field 10:0 is message code when bit 13 set; transmit reset 0x1
// RULE9 - software sets transmit bit 12 when the local side will comply
// RULE10 - toggle bit 11 is driven as inverse of the previous code word's toggle
// RULE11 - each received next page is captured at index 8, code resetting to 0x0
// RULE12 - received toggle 0 means the previous code word's toggle was 1
// RULE13 - a 100 Mb/s parallel-detected link sets the partner 100 Mb/s ability bit
// RULE14 - read-clear bits clear only on a completed read; same-cycle events stay
module autoneg_next_page_regs
  import autoneg_np_pkg::*;
(
  input  wire logic              CLK,
  input  wire logic              RST,
  input  wire logic [ADDR_W-1:0] AWADDR,
  input  wire logic              AWVALID,
  output var  logic              AWREADY,
  input  wire logic [DATA_W-1:0] WDATA,
  input  wire logic [3:0]        WSTRB,
  input  wire logic              WVALID,
  output var  logic              WREADY,
  output var  logic [1:0]        BRESP,
  output var  logic              BVALID,
  input  wire logic              BREADY,
  input  wire logic [ADDR_W-1:0] ARADDR,
  input  wire logic              ARVALID,
  output var  logic              ARREADY,
  output var  logic [DATA_W-1:0] RDATA,
  output var  logic [1:0]        RRESP,
  output var  logic              RVALID,
  input  wire logic              RREADY,
  input  wire logic              PD_FAULT,
  input  wire logic              PD_LINK_100,
  input  wire logic              PARTNER_NP_ABLE,
  input  wire logic              PARTNER_AN_ABLE,
  input  wire logic              BASE_PAGE_STROBE,
  input  wire logic [15:0]       BASE_PAGE,
  input  wire logic              NEXT_PAGE_STROBE,
  input  wire np_word_s          NEXT_PAGE,
  input  wire logic              NP_EXCHANGED,
  input  wire logic              AN_RESTART,
  output var  np_word_s          NP_TX_WORD,
  output var  logic              AN_ENABLE,
  output var  logic              IRQ
);

  reg_wr_s           wr;
  logic [IDX_W-1:0]  rd_idx;
  logic [IDX_W-1:0]  rd_done_idx;
  logic              rd_fire;
  logic [DATA_W-1:0] rd_data;
  logic              rd_ok;
  logic              wr_ok;

  reg_bus_slave u_bus (
    .clk         (CLK),
    .rst         (RST),
    .awaddr      (AWADDR),
    .awvalid     (AWVALID),
    .awready     (AWREADY),
    .wdata       (WDATA),
    .wstrb       (WSTRB),
    .wvalid      (WVALID),
    .wready      (WREADY),
    .bresp       (BRESP),
    .bvalid      (BVALID),
    .bready      (BREADY),
    .araddr      (ARADDR),
    .arvalid     (ARVALID),
    .arready     (ARREADY),
    .rdata       (RDATA),
    .rresp       (RRESP),
    .rvalid      (RVALID),
    .rready      (RREADY),
    .wr          (wr),
    .wr_ok       (wr_ok),
    .rd_idx      (rd_idx),
    .rd_data     (rd_data),
    .rd_ok       (rd_ok),
    .rd_fire     (rd_fire),
    .rd_done_idx (rd_done_idx)
  );

  // register state
  logic             pd_fault_seen, next_pd_fault_seen;
  logic             page_rx_seen, next_page_rx_seen;
  np_word_s         np_tx, next_np_tx;
  np_word_s         np_rx, next_np_rx;
  logic [15:0]      partner_ability_register, next_partner_ability_register;
  logic             an_enable, next_an_enable;
  logic             tx_toggle, next_tx_toggle;
  logic [IRQ_W-1:0] irq_status, next_irq_status;
  logic [IRQ_W-1:0] irq_mask, next_irq_mask;
  logic             irq, next_irq;

  logic [15:0]      lane_mask;
  logic [15:0]      wr_word;
  logic             exp_read_done;
  logic             page_event;
  logic [IRQ_W-1:0] irq_events;

  // 16-bit registers use the two low byte lanes only
  assign lane_mask     = {{8{wr.strb[1]}}, {8{wr.strb[0]}}};
  assign wr_word       = wr.data[15:0];
  assign exp_read_done = rd_fire && (rd_done_idx == IDX_EXPANSION); // [RULE14]
  assign page_event    = BASE_PAGE_STROBE || NEXT_PAGE_STROBE;
  assign irq_events    = {page_event, PD_FAULT};

  always_comb begin
    wr_ok = 1'b0;
    unique case (wr.idx)
      IDX_PARTNER_ABILITY, IDX_EXPANSION, IDX_NP_TRANSMIT, IDX_NP_RECEIVED,
      IDX_CONTROL, IDX_IRQ_STATUS, IDX_IRQ_MASK: wr_ok = 1'b1;
      default: wr_ok = 1'b0;
    endcase
  end

  // read mux; bits above the register width and reserved bits read zero
  always_comb begin
    rd_data = '0;
    rd_ok   = 1'b1;
    unique case (rd_idx)
      IDX_PARTNER_ABILITY: begin
        rd_data[15:0] = partner_ability_register;
      end
      IDX_EXPANSION: begin
        rd_data[EXP_PD_FAULT]   = pd_fault_seen; // [RULE1]
        rd_data[EXP_PARTNER_NP] = PARTNER_NP_ABLE; // [RULE2]
        rd_data[EXP_LOCAL_NP]   = LOCAL_NP_ABLE_RESET; // [RULE3]
        rd_data[EXP_PAGE_RX]    = page_rx_seen; // [RULE4]
        rd_data[EXP_PARTNER_AN] = an_enable && PARTNER_AN_ABLE; // [RULE5]
      end
      IDX_NP_TRANSMIT: begin
        rd_data[15:0] = np_tx; // [RULE6]
      end
      IDX_NP_RECEIVED: begin
        rd_data[15:0] = np_rx; // [RULE11]
      end
      IDX_CONTROL: begin
        rd_data[CTRL_AN_ENABLE] = an_enable;
      end
      IDX_IRQ_STATUS: begin
        rd_data[IRQ_W-1:0] = irq_status;
      end
      IDX_IRQ_MASK: begin
        rd_data[IRQ_W-1:0] = irq_mask;
      end
      default: begin
        rd_ok = 1'b0;
      end
    endcase
  end

  // expansion read-clear bits: only bits actually returned as 1 are cleared,
  // so an event landing between address accept and the handshake is not lost
  always_comb begin
    next_pd_fault_seen = pd_fault_seen;
    next_page_rx_seen  = page_rx_seen;
    if (exp_read_done && RDATA[EXP_PD_FAULT]) begin
      next_pd_fault_seen = 1'b0; // [RULE14]
    end
    if (exp_read_done && RDATA[EXP_PAGE_RX]) begin
      next_page_rx_seen = 1'b0; // [RULE14]
    end
    if (PD_FAULT) begin
      next_pd_fault_seen = 1'b1; // [RULE1]
    end
    if (page_event) begin
      next_page_rx_seen = 1'b1; // [RULE4]
    end
  end

  // transmit page: software owns more, message, acknowledge-two and code;
  // toggle is hardware's and ignores writes
  always_comb begin
    next_np_tx     = np_tx;
    next_tx_toggle = tx_toggle;
    if (wr.en && wr.idx == IDX_NP_TRANSMIT) begin
      next_np_tx.more = lane_mask[15] ? wr_word[15] : np_tx.more; // [RULE7]
      next_np_tx.message_page_select =
        lane_mask[13] ? wr_word[13] : np_tx.message_page_select; // [RULE8]
      next_np_tx.acknowledge_two =
        lane_mask[12] ? wr_word[12] : np_tx.acknowledge_two; // [RULE9]
      next_np_tx.page_code_field =
        (wr_word[10:0] & lane_mask[10:0]) |
        (np_tx.page_code_field & ~lane_mask[10:0]); // [RULE8]
    end
    if (AN_RESTART) begin
      next_tx_toggle = 1'b0;
    end else if (NP_EXCHANGED) begin
      next_tx_toggle = ~tx_toggle; // [RULE10]
    end
    next_np_tx.rsvd   = 1'b0;
    next_np_tx.toggle = next_tx_toggle; // [RULE10]
  end

  // received page is stored as sent, so toggle 0 marks a previous toggle of 1
  always_comb begin
    next_np_rx = np_rx;
    if (NEXT_PAGE_STROBE) begin
      next_np_rx      = NEXT_PAGE; // [RULE11] [RULE12]
      next_np_rx.rsvd = 1'b0;
    end
  end

  // partner ability: base page load, plus parallel-detect 100 Mb/s; the set wins
  always_comb begin
    next_partner_ability_register = partner_ability_register;
    if (BASE_PAGE_STROBE) begin
      next_partner_ability_register = BASE_PAGE;
    end
    if (PD_LINK_100) begin
      next_partner_ability_register[LPA_100TX] = 1'b1; // [RULE13]
    end
  end

  // control, interrupt status (write one to clear, set wins) and mask
  always_comb begin
    next_an_enable  = an_enable;
    next_irq_mask   = irq_mask;
    next_irq_status = irq_status;
    if (wr.en && wr.idx == IDX_CONTROL && wr.strb[0]) begin
      next_an_enable = wr.data[CTRL_AN_ENABLE];
    end
    if (wr.en && wr.idx == IDX_IRQ_MASK && wr.strb[0]) begin
      next_irq_mask = wr.data[IRQ_W-1:0];
    end
    if (wr.en && wr.idx == IDX_IRQ_STATUS && wr.strb[0]) begin
      next_irq_status = irq_status & ~wr.data[IRQ_W-1:0];
    end
    next_irq_status = next_irq_status | irq_events;
    next_irq        = |(next_irq_status & next_irq_mask);
  end

  // read-clear flags
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      pd_fault_seen <= 1'b0;
      page_rx_seen  <= 1'b0;
    end else begin
      pd_fault_seen <= next_pd_fault_seen;
      page_rx_seen  <= next_page_rx_seen;
    end
  end

  // transmit page and hardware toggle
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      np_tx     <= '{more: 1'b0, rsvd: 1'b0, message_page_select: 1'b0,
                     acknowledge_two: 1'b0, toggle: 1'b0,
                     page_code_field: NP_TX_CODE_RESET};
      tx_toggle <= 1'b0;
    end else begin
      np_tx     <= next_np_tx;
      tx_toggle <= next_tx_toggle;
    end
  end

  // captured partner next page
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      np_rx <= '{more: 1'b0, rsvd: 1'b0, message_page_select: 1'b0,
                 acknowledge_two: 1'b0, toggle: 1'b0,
                 page_code_field: NP_RX_CODE_RESET};
    end else begin
      np_rx <= next_np_rx;
    end
  end

  // partner ability word
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      partner_ability_register <= LPA_RESET;
    end else begin
      partner_ability_register <= next_partner_ability_register;
    end
  end

  // control and interrupt; irq is a flop so the pin never glitches
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      an_enable  <= AN_ENABLE_RESET;
      irq_status <= '0;
      irq_mask   <= IRQ_MASK_RESET;
      irq        <= 1'b0;
    end else begin
      an_enable  <= next_an_enable;
      irq_status <= next_irq_status;
      irq_mask   <= next_irq_mask;
      irq        <= next_irq;
    end
  end

  assign NP_TX_WORD = np_tx;
  assign AN_ENABLE  = an_enable;
  assign IRQ        = irq;

endmodule : autoneg_next_page_regs
`default_nettype wire

// ==== autoneg_np_props.sv ====
// assertions on the next-page register bank ports
`timescale 1ns/1ps
`default_nettype none
module autoneg_np_props
  import autoneg_np_pkg::*;
(
  input wire logic              CLK,
  input wire logic              RST,
  input wire logic [ADDR_W-1:0] ARADDR,
  input wire logic              ARVALID,
  input wire logic              ARREADY,
  input wire logic [DATA_W-1:0] RDATA,
  input wire logic [1:0]        RRESP,
  input wire logic              RVALID,
  input wire logic              RREADY,
  input wire logic              AWVALID,
  input wire logic              AWREADY,
  input wire logic              WVALID,
  input wire logic              WREADY,
  input wire logic [1:0]        BRESP,
  input wire logic              BVALID,
  input wire logic              BREADY,
  input wire logic              PD_FAULT,
  input wire logic              PARTNER_NP_ABLE,
  input wire logic              PARTNER_AN_ABLE,
  input wire logic              NP_EXCHANGED,
  input wire logic              AN_RESTART,
  input wire logic              AN_ENABLE,
  input wire np_word_s          NP_TX_WORD
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);
  // index of the read in flight, so read data can be tied to its register
  logic [IDX_W-1:0] ar_idx;
  logic [IDX_W-1:0] next_ar_idx;
  always_comb next_ar_idx = (ARVALID && ARREADY) ? ARADDR[7:2] : ar_idx;
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) ar_idx <= '0;
    else ar_idx <= next_ar_idx;
  end
  sequence s_ar; ARVALID && ARREADY; endsequence
  sequence s_wr; AWVALID && AWREADY && WVALID && WREADY; endsequence
  sequence s_exp; $rose(RVALID) && ar_idx == IDX_EXPANSION && RRESP == RESP_OKAY; endsequence
  a_read_answer: assert property (s_ar |=> RVALID && !ARREADY)
    else $error("read not answered in one cycle");
  a_write_answer: assert property (s_wr |=> ##1 BVALID)
    else $error("write not answered in two cycles");
  a_rdata_hold: assert property (RVALID && !RREADY |=> RVALID && $stable(RDATA))
    else $error("read data dropped before taken");
  a_bresp_hold: assert property (BVALID && !BREADY |=> BVALID && $stable(BRESP))
    else $error("write response dropped before taken");
  a_local_np_one: assert property (s_exp |-> RDATA[EXP_LOCAL_NP])
    else $error("local next-page ability reads 0");
  a_pd_fault_seen: assert property (s_exp ##0 $past(PD_FAULT, 2) |-> RDATA[EXP_PD_FAULT])
    else $error("fault event missing from read");
  a_partner_bits: assert property (s_exp |-> RDATA[EXP_PARTNER_NP] == $past(PARTNER_NP_ABLE)
    && RDATA[EXP_PARTNER_AN] == $past(AN_ENABLE && PARTNER_AN_ABLE))
    else $error("partner ability bits wrong");
  a_toggle_flip: assert property (NP_EXCHANGED && !AN_RESTART |=>
    NP_TX_WORD.toggle != $past(NP_TX_WORD.toggle))
    else $error("toggle did not invert");
  a_toggle_clear: assert property (AN_RESTART |=> !NP_TX_WORD.toggle)
    else $error("toggle not cleared on restart");
endmodule : autoneg_np_props
bind autoneg_next_page_regs autoneg_np_props u_props (.*);
`default_nettype wire

// ==== axi_lite_master.sv ====
// management software model: one AXI4-Lite write or read at a time
`timescale 1ns/1ps
`default_nettype none
module axi_lite_master
  import autoneg_np_pkg::*;
(
  input  wire logic              clk,
  output var  logic [ADDR_W-1:0] awaddr,
  output var  logic              awvalid,
  input  wire logic              awready,
  output var  logic [DATA_W-1:0] wdata,
  output var  logic [3:0]        wstrb,
  output var  logic              wvalid,
  input  wire logic              wready,
  input  wire logic [1:0]        bresp,
  input  wire logic              bvalid,
  output var  logic              bready,
  output var  logic [ADDR_W-1:0] araddr,
  output var  logic              arvalid,
  input  wire logic              arready,
  input  wire logic [DATA_W-1:0] rdata,
  input  wire logic [1:0]        rresp,
  input  wire logic              rvalid,
  output var  logic              rready
);
  int n_to = 0;
  int slow = 0; // cycles before bready or rready rises, to exercise response hold
  initial begin
    {awaddr, awvalid, wdata, wvalid, bready, araddr, arvalid, rready} = '0;
    wstrb = 4'hF;
  end
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] dd,
                    output logic [1:0] rr);
    int k;
    @(posedge clk);
    awaddr <= a;
    wdata <= dd;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= (slow == 0);
    for (k = 0; k < 64; k++) begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid && bready) break;
      if (k + 1 >= slow) bready <= 1'b1;
    end
    rr = bresp;
    bready <= 1'b0;
    // released data must not look like the last word
    wdata <= ~dd;
    if (k == 64) n_to++;
  endtask : wr
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] dd,
                    output logic [1:0] rr);
    int k;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= (slow == 0);
    for (k = 0; k < 64; k++) begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
      if (rvalid && rready) break;
      if (k + 1 >= slow) rready <= 1'b1;
    end
    dd = rdata;
    rr = rresp;
    rready <= 1'b0;
    if (k == 64) n_to++;
  endtask : rd
endmodule : axi_lite_master
`default_nettype wire

// ==== tb_autoneg_next_page_regs.sv ====
// self-checking bench for the next-page register bank
`timescale 1ns/1ps
`default_nettype none
module tb_autoneg_next_page_regs import autoneg_np_pkg::*;;
  logic              CLK = 1'b0;
  logic              RST = 1'b1;
  logic [ADDR_W-1:0] AWADDR, ARADDR;
  logic [DATA_W-1:0] WDATA, RDATA, d;
  logic [3:0]        WSTRB;
  logic [1:0]        BRESP, RRESP, r;
  logic              AWVALID, AWREADY, WVALID, WREADY, BVALID, BREADY, IRQ;
  logic              ARVALID, ARREADY, RVALID, RREADY, AN_ENABLE, AN_RESTART;
  logic              PD_FAULT, PD_LINK_100, PARTNER_NP_ABLE, PARTNER_AN_ABLE;
  logic              BASE_PAGE_STROBE, NEXT_PAGE_STROBE, NP_EXCHANGED;
  logic [15:0]       BASE_PAGE;
  np_word_s          NEXT_PAGE, NP_TX_WORD;
  int                n_fail = 0;
  int                compares = 0;
  typedef struct {logic [7:0] a; logic [31:0] v; logic [1:0] rs;} row_s;
  row_s rows [9] = '{'{8'h14, 32'h0, RESP_OKAY}, '{8'h18, 32'h4, RESP_OKAY},
    '{8'h1C, 32'h1, RESP_OKAY}, '{8'h20, 32'h0, RESP_OKAY}, '{8'h40, 32'h1, RESP_OKAY},
    '{8'h44, 32'h0, RESP_OKAY}, '{8'h48, 32'h0, RESP_OKAY}, '{8'h00, 32'h0, RESP_SLVERR},
    '{8'h4C, 32'h0, RESP_SLVERR}};
  always #25 CLK = ~CLK;
  autoneg_next_page_regs dut (.*);
  axi_lite_master m (.clk(CLK), .awaddr(AWADDR), .awvalid(AWVALID), .awready(AWREADY),
    .wdata(WDATA), .wstrb(WSTRB), .wvalid(WVALID), .wready(WREADY), .bresp(BRESP),
    .bvalid(BVALID), .bready(BREADY), .araddr(ARADDR), .arvalid(ARVALID),
    .arready(ARREADY), .rdata(RDATA), .rresp(RRESP), .rvalid(RVALID), .rready(RREADY));
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    m.rd(a, d, r);
    chk("rdata", e, d);
  endtask : rdchk
  task automatic rows_check;
    foreach (rows[i]) begin
      m.rd(rows[i].a, d, r);
      chk("rdata", rows[i].v, d);
      chk("rresp", rows[i].rs, r);
    end
    $display("test reset values done");
  endtask : rows_check
  task automatic print_verdict;
    n_fail += m.n_to;
    $display("checks %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : print_verdict
  initial begin
    repeat (6000) @(posedge CLK);
    n_fail++;
    print_verdict();
  end
  initial begin
    {PD_FAULT, PD_LINK_100, PARTNER_NP_ABLE, PARTNER_AN_ABLE, AN_RESTART} = '0;
    {BASE_PAGE_STROBE, NEXT_PAGE_STROBE, NP_EXCHANGED, BASE_PAGE, NEXT_PAGE} = '0;
    repeat (20) @(posedge CLK);
    RST <= 1'b0;
    rows_check();
    m.wr(8'h48, 32'h3, r);
    @(posedge CLK);
    PD_FAULT <= 1'b1;
    @(posedge CLK);
    PD_FAULT <= 1'b0;
    @(posedge CLK);
    chk("irq", 32'h1, IRQ);
    rdchk(8'h18, 32'h14);
    rdchk(8'h18, 32'h04);
    // event lands on the read's handshake edge and must survive it
    fork
      m.rd(8'h18, d, r);
      begin
        PD_FAULT <= 1'b1;
        @(posedge CLK);
        PD_FAULT <= 1'b0;
        @(posedge CLK);
        PD_FAULT <= 1'b1;
        @(posedge CLK);
        PD_FAULT <= 1'b0;
      end
    join
    chk("rdata", 32'h14, d);
    m.slow = 3;
    rdchk(8'h18, 32'h14);
    m.wr(8'h44, 32'h3, r);
    m.slow = 0;
    @(posedge CLK);
    chk("irq", 32'h0, IRQ);
    $display("test fault and irq done");
    NEXT_PAGE <= 16'hF805;
    NEXT_PAGE_STROBE <= 1'b1;
    @(posedge CLK);
    NEXT_PAGE_STROBE <= 1'b0;
    @(posedge CLK);
    chk("irq", 32'h1, IRQ);
    rdchk(8'h20, 32'hB805);
    rdchk(8'h18, 32'h06);
    rdchk(8'h18, 32'h04);
    m.wr(8'h48, 32'h0, r);
    @(posedge CLK);
    chk("irq", 32'h0, IRQ);
    m.wr(8'h20, 32'hFFFF, r);
    chk("bresp", RESP_OKAY, r);
    rdchk(8'h20, 32'hB805);
    m.wr(8'h00, 32'hFFFF, r);
    chk("bresp", RESP_SLVERR, r);
    $display("test page received done");
    m.wr(8'h1C, 32'hFFFF, r);
    rdchk(8'h1C, 32'hB7FF);
    chk("tx_word", 32'hB7FF, NP_TX_WORD);
    m.wstrb <= 4'h1;
    m.wr(8'h1C, 32'h0, r);
    m.wstrb <= 4'hF;
    rdchk(8'h1C, 32'hB700);
    m.wr(8'h1C, 32'h0001, r);
    rdchk(8'h1C, 32'h0001);
    NP_EXCHANGED <= 1'b1;
    repeat (3) @(posedge CLK);
    NP_EXCHANGED <= 1'b0;
    @(posedge CLK);
    chk("tx_word", 32'h0801, NP_TX_WORD);
    rdchk(8'h1C, 32'h0801);
    AN_RESTART <= 1'b1;
    @(posedge CLK);
    AN_RESTART <= 1'b0;
    @(posedge CLK);
    chk("tx_word", 32'h0001, NP_TX_WORD);
    $display("test transmit page done");
    PD_LINK_100 <= 1'b1;
    @(posedge CLK);
    PD_LINK_100 <= 1'b0;
    rdchk(8'h14, 32'h80);
    BASE_PAGE <= 16'h1234;
    BASE_PAGE_STROBE <= 1'b1;
    PD_LINK_100 <= 1'b1;
    @(posedge CLK);
    {BASE_PAGE_STROBE, PD_LINK_100} <= 2'h0;
    rdchk(8'h14, 32'h12B4);
    $display("test parallel detection done");
    PARTNER_NP_ABLE <= 1'b1;
    PARTNER_AN_ABLE <= 1'b1;
    rdchk(8'h18, 32'h0F);
    m.wr(8'h40, 32'h0, r);
    @(posedge CLK);
    chk("an_enable", 32'h0, AN_ENABLE);
    rdchk(8'h18, 32'h0C);
    $display("test partner ability done");
    {PARTNER_NP_ABLE, PARTNER_AN_ABLE} <= 2'h0;
    RST <= 1'b1;
    repeat (2) @(posedge CLK);
    RST <= 1'b0;
    rows_check();
    print_verdict();
  end
endmodule : tb_autoneg_next_page_regs
`default_nettype wire
